// [rtl/wdog_pkg.sv]
// Constants, types and timing tables for the pin-selectable watchdog
package wdog_pkg;

  localparam int unsigned CLOCK_HZ = 25_000_000;
  localparam int unsigned CLOCK_PERIOD_NS = 40;

  typedef enum logic [1:0] {
    VARIANT_EQUAL = 2'h0,
    VARIANT_LONG_START = 2'h1,
    VARIANT_FAST = 2'h2
  } variant_t;

  localparam logic [2:0] SEL_DISABLE = 3'h3;
  localparam int CNT_W = 32;

  localparam longint unsigned US_PER_S = 1_000_000;

  function automatic logic [CNT_W-1:0] us_to_cycles(input longint unsigned t_us);
    longint unsigned c;
    c = (t_us * CLOCK_HZ + US_PER_S - 1) / US_PER_S;
    if (c < 1) begin
      c = 1;
    end
    return c[CNT_W-1:0];
  endfunction

  // Times in microseconds, indexed by select code
  localparam longint unsigned TMO_EQUAL_US [8] = '{
    1_000, 10_000, 30_000, 0, 100_000, 1_000_000, 10_000_000, 60_000_000};
  localparam longint unsigned TMO_LONG_US [8] = '{
    1_000, 3_000, 10_000, 0, 100_000, 300_000, 3_000_000, 60_000_000};
  localparam longint unsigned TMO_FAST_US [8] = '{
    3_000, 3_000_000, 1_000_000, 0, 30, 1_000_000, 10_000_000, 10_000_000};
  localparam longint unsigned START_FAST_US [8] = '{
    3_000, 3_000_000, 60_000_000, 0, 200, 0, 0, 60_000_000};
  localparam longint unsigned START_LONG_US = 60_000_000;

  localparam longint unsigned PULSE_OPEN_DRAIN_US = 100_000;
  localparam longint unsigned PULSE_PUSH_PULL_US = 1_000;
  localparam longint unsigned SETTLE_US = 300;

  localparam logic [2:0] SEL_FIRST_EDGE_A = 3'h5;
  localparam logic [2:0] SEL_FIRST_EDGE_B = 3'h6;

  typedef enum logic [1:0] {
    ST_SETTLE = 2'b00,
    ST_STARTUP = 2'b01,
    ST_WATCH = 2'b11,
    ST_FAULT = 2'b10
  } wd_state_t;

endpackage

// [rtl/sync_if.sv]
// Synchronised strobe and select lines passed from the input stage
`timescale 1ns/100ps
`default_nettype none
interface sync_if;
  logic strobe_edge;
  logic [2:0] sel;
  logic sel_change;
  modport source (output strobe_edge, output sel, output sel_change);
  modport sink (input strobe_edge, input sel, input sel_change);
endinterface
`default_nettype wire

// [rtl/input_sync.sv]
// Three-stage synchronisers with agreement-based change detection
`timescale 1ns/100ps
`default_nettype none
module input_sync
  import wdog_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // Raw pins
  input wire logic strobe_in_i,
  input wire logic [2:0] timing_sel_i,
  // Synchronised outputs
  sync_if.source out
);

  logic [3:0] s1;
  logic [3:0] s2;
  logic [3:0] s3;
  logic [3:0] stable;
  logic primed;
  logic [2:0] fill;

  // Stage one is read only by stage two; fill marks stages that hold pin data,
  // so the reset zeros never count as a strobe edge or a select change
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s1 <= 4'h0;
      s2 <= 4'h0;
      s3 <= 4'h0;
      fill <= 3'h0;
    end else begin
      s1 <= {timing_sel_i, strobe_in_i};
      s2 <= s1;
      s3 <= s2;
      fill <= {fill[1:0], 1'b1};
    end
  end

  // A change counts once stages two and three agree
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      stable <= 4'h0;
      primed <= 1'b0;
      out.strobe_edge <= 1'b0;
      out.sel_change <= 1'b0;
    end else begin
      out.strobe_edge <= 1'b0;
      out.sel_change <= 1'b0;
      if (s2 == s3) begin
        primed <= fill[2];
        stable <= s3;
        if (primed) begin
          out.strobe_edge <= s3[0] != stable[0];
          out.sel_change <= s3[3:1] != stable[3:1];
        end
      end
    end
  end

  assign out.sel = stable[3:1];

endmodule
`default_nettype wire

// [rtl/pin_selectable_watchdog.sv]
// Watchdog supervisor with pin-selected startup delay and timeout
// Operation
// - Constant strobe over timeout gives fault pulse
// - Strobe edge clears watchdog counter
// - Fault assertion clears watchdog counter
// - Fault pulse width per output variant
// - Fault stays high while strobe toggles
// - Startup delay at power-up and select change
// - No countdown or fault during startup
// - After startup, count timeout, watch strobe
// - Equal variant: startup equals timeout table
// - Long variant: sixty second startup, table
// - Fast variant startup delay table
// - Fast variant timeout table
// - First-edge setting ends startup on edge
// - Disable code turns watchdog off
// - Ignore strobe during fault, and during startup unless first-edge
// - Ignore strobe during select settle time
// - Timing restarts when fault pulse ends
// - Disabled watchdog holds fault output high
`timescale 1ns/100ps
`default_nettype none
module pin_selectable_watchdog
  import wdog_pkg::*;
#(
  parameter variant_t VARIANT = VARIANT_EQUAL,
  parameter bit PUSH_PULL = 1'b1,
  parameter logic [CNT_W-1:0] SETTLE_CYCLES = us_to_cycles(SETTLE_US),
  parameter logic [CNT_W-1:0] PULSE_CYCLES =
    us_to_cycles(PUSH_PULL ? PULSE_PUSH_PULL_US : PULSE_OPEN_DRAIN_US),
  parameter int unsigned TIME_DIV = 1
)(
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // Host strobe and timing select pins
  input wire logic strobe_in_i,
  input wire logic timing_sel_0_i,
  input wire logic timing_sel_1_i,
  input wire logic timing_sel_2_i,
  // Fault output, active low, and its enable
  output logic fault_pulse_n_o,
  output logic fault_pulse_oe_o
);

  // ==========================================================
  // Reset release
  logic rst_m;
  logic rst_b;

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_m <= 1'b0;
      rst_b <= 1'b0;
    end else begin
      rst_m <= 1'b1;
      rst_b <= rst_m;
    end
  end

  // ==========================================================
  // Input synchronisation
  sync_if sync ();

  input_sync u_sync (
    .clock_i(clock_i),
    .rst_b_i(rst_b),
    .strobe_in_i(strobe_in_i),
    .timing_sel_i({timing_sel_2_i, timing_sel_1_i, timing_sel_0_i}),
    .out(sync.source)
  );

  // ==========================================================
  // Period tables
  function automatic logic [CNT_W-1:0] scaled(input longint unsigned t_us);
    logic [CNT_W-1:0] c;
    c = us_to_cycles(t_us) / CNT_W'(TIME_DIV);
    if (c == '0) begin
      c = CNT_W'(1);
    end
    return c;
  endfunction

  function automatic logic [CNT_W-1:0] timeout_of(input logic [2:0] sel);
    logic [CNT_W-1:0] c;
    c = '0;
    unique case (VARIANT)
      VARIANT_EQUAL: c = scaled(TMO_EQUAL_US[sel]);
      VARIANT_LONG_START: c = scaled(TMO_LONG_US[sel]);
      default: c = scaled(TMO_FAST_US[sel]);
    endcase
    return c;
  endfunction

  function automatic logic [CNT_W-1:0] startup_of(input logic [2:0] sel);
    logic [CNT_W-1:0] c;
    c = '0;
    unique case (VARIANT)
      VARIANT_EQUAL: c = scaled(TMO_EQUAL_US[sel]);
      VARIANT_LONG_START: c = scaled(START_LONG_US);
      default: c = scaled(START_FAST_US[sel]);
    endcase
    return c;
  endfunction

  // ==========================================================
  // Period lookup per select code, constant after elaboration
  localparam int SEL_W = $bits(SEL_DISABLE);
  localparam int SEL_CODES = $size(TMO_EQUAL_US);

  logic [CNT_W-1:0] timeout_table [SEL_CODES];
  logic [CNT_W-1:0] startup_table [SEL_CODES];

  for (genvar g = 0; g < SEL_CODES; g++) begin : g_period
    assign timeout_table[g] = timeout_of(SEL_W'(g));
    assign startup_table[g] = startup_of(SEL_W'(g));
  end

  // Registered to keep the table mux off the compare path; a select change
  // always passes the settle phase first, which hides the one-cycle lag
  logic [CNT_W-1:0] timeout_cycles;
  logic [CNT_W-1:0] startup_cycles;

  always_ff @(posedge clock_i or negedge rst_b) begin
    if (!rst_b) begin
      timeout_cycles <= '1;
      startup_cycles <= '1;
    end else begin
      timeout_cycles <= timeout_table[sync.sel];
      startup_cycles <= startup_table[sync.sel];
    end
  end

  // ==========================================================
  // Select decode
  logic first_edge_sel;
  logic disabled;

  assign first_edge_sel = (VARIANT == VARIANT_FAST) &&
    ((sync.sel == SEL_FIRST_EDGE_A) || (sync.sel == SEL_FIRST_EDGE_B));
  assign disabled = sync.sel == SEL_DISABLE;

  // ==========================================================
  // Supervisor state machine
  wd_state_t state;
  wd_state_t next_state;
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic pending_change;
  logic next_pending_change;

  always_comb begin
    next_state = state;
    next_count = count + CNT_W'(1);
    next_pending_change = pending_change | sync.sel_change;
    unique case (state)
      ST_SETTLE: begin
        next_pending_change = 1'b0;
        if (sync.sel_change) begin
          next_count = '0;
        end else if (disabled) begin
          next_count = '0;
        end else if (count + CNT_W'(1) >= SETTLE_CYCLES) begin
          next_state = ST_STARTUP;
          next_count = '0;
        end
      end
      ST_STARTUP: begin
        // no fault, strobe ignored unless first-edge
        next_pending_change = 1'b0;
        if (sync.sel_change) begin
          next_state = ST_SETTLE;
          next_count = '0;
        end else if (first_edge_sel) begin
          next_count = '0;
          if (sync.strobe_edge) begin
            next_state = ST_WATCH;
          end
        end else if (count + CNT_W'(1) >= startup_cycles) begin
          next_state = ST_WATCH;
          next_count = '0;
        end
      end
      ST_WATCH: begin
        next_pending_change = 1'b0;
        if (sync.sel_change) begin
          next_state = ST_SETTLE;
          next_count = '0;
        end else if (sync.strobe_edge) begin
          next_count = '0;
        end else if (count + CNT_W'(1) >= timeout_cycles) begin
          next_state = ST_FAULT;
          next_count = '0;
        end
      end
      ST_FAULT: begin
        // strobe ignored, previous pulse finishes on a select change
        if (count + CNT_W'(1) >= PULSE_CYCLES) begin
          next_count = '0;
          next_pending_change = 1'b0;
          if (pending_change || sync.sel_change) begin
            next_state = ST_SETTLE;
          end else begin
            next_state = ST_WATCH;
          end
        end
      end
    endcase
  end

  // Power-up begins in the settle phase
  always_ff @(posedge clock_i or negedge rst_b) begin
    if (!rst_b) begin
      state <= ST_SETTLE;
    end else begin
      state <= next_state;
    end
  end

  // Shared period counter: settle, startup, timeout and pulse width
  always_ff @(posedge clock_i or negedge rst_b) begin
    if (!rst_b) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  // Select change held over while a pulse runs
  always_ff @(posedge clock_i or negedge rst_b) begin
    if (!rst_b) begin
      pending_change <= 1'b0;
    end else begin
      pending_change <= next_pending_change;
    end
  end

  // ==========================================================
  // Output drive
  always_ff @(posedge clock_i or negedge rst_b) begin
    if (!rst_b) begin
      fault_pulse_n_o <= 1'b1;
      fault_pulse_oe_o <= PUSH_PULL;
    end else begin
      // never low outside the fault state
      fault_pulse_n_o <= next_state != ST_FAULT;
      fault_pulse_oe_o <= PUSH_PULL | (next_state == ST_FAULT);
    end
  end

endmodule
`default_nettype wire

// [test/wdog_chk.sv]
// Port-level assertion checker for the watchdog
`timescale 1ns/100ps
`default_nettype none
module wdog_chk #(
  parameter int PULSE = 30,
  parameter int SETTLE = 20,
  parameter int T0 = 250,
  parameter bit PP = 1'b1
)(
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic strobe_in_i,
  input wire logic timing_sel_0_i,
  input wire logic timing_sel_1_i,
  input wire logic timing_sel_2_i,
  input wire logic fault_pulse_n_o,
  input wire logic fault_pulse_oe_o
);
  logic [2:0] sel;
  logic [2:0] sel_q;
  logic str_q;
  int low_cnt, quiet, since, hold, dis;
  assign sel = {timing_sel_2_i, timing_sel_1_i, timing_sel_0_i};
  // ========
  // Cycle counters
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sel_q <= sel;
      str_q <= strobe_in_i;
      {low_cnt, quiet, since, hold, dis} <= '0;
    end else begin
      sel_q <= sel;
      str_q <= strobe_in_i;
      low_cnt <= fault_pulse_n_o ? 0 : low_cnt + 1;
      quiet <= (strobe_in_i != str_q) ? 0 : quiet + 1;
      since <= (sel != sel_q) ? 0 : since + 1;
      hold <= (strobe_in_i != str_q || sel != sel_q || !fault_pulse_n_o) ? 0 : hold + 1;
      dis <= (sel == 3'h3 && sel == sel_q) ? dis + 1 : 0;
    end
  end
  // ========
  // Properties
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  sequence s_rel;
    $rose(fault_pulse_n_o);
  endsequence
  AST_PULSE_WIDTH: assert property (s_rel |-> low_cnt == PULSE)
    else $error("fault pulse width wrong");
  AST_DRIVE_EN: assert property (fault_pulse_oe_o == (PP | !fault_pulse_n_o))
    else $error("drive enable wrong");
  AST_DISABLED_HIGH: assert property (dis > PULSE + 8 |-> fault_pulse_n_o)
    else $error("fault while disabled");
  AST_QUIET_FIRST: assert property ($fell(fault_pulse_n_o) |-> quiet >= T0)
    else $error("fault despite strobe");
  AST_NO_EARLY: assert property ($fell(fault_pulse_n_o) |-> since >= SETTLE + 2 * T0)
    else $error("fault before startup end");
  AST_BOUND: assert property (sel == 3'h0 |-> hold <= SETTLE + 2 * T0 + 16)
    else $error("missing fault pulse");
  AST_RESTART: assert property (s_rel |-> ##1 fault_pulse_n_o[*8])
    else $error("fault right after pulse");
  AST_RESET_HIGH: assert property ($rose(rst_b_i) |-> fault_pulse_n_o)
    else $error("fault at reset release");
endmodule
bind pin_selectable_watchdog wdog_chk #(.PULSE(int'(PULSE_CYCLES)),
  .SETTLE(int'(SETTLE_CYCLES)), .T0(250), .PP(PUSH_PULL)) u_chk (
  .clock_i(clock_i), .rst_b_i(rst_b_i), .strobe_in_i(strobe_in_i),
  .timing_sel_0_i(timing_sel_0_i), .timing_sel_1_i(timing_sel_1_i),
  .timing_sel_2_i(timing_sel_2_i), .fault_pulse_n_o(fault_pulse_n_o),
  .fault_pulse_oe_o(fault_pulse_oe_o));
`default_nettype wire

// [test/host_model.sv]
// Host model that toggles the strobe at a set spacing
`timescale 1ns/100ps
`default_nettype none
module host_model (
  input wire logic clock_i,
  input wire logic run_i,
  input wire logic [15:0] gap_i,
  output logic strobe_o
);
  logic [15:0] cnt = 16'h0;
  initial strobe_o = 1'b0;
  always @(negedge clock_i) begin
    if (run_i && cnt >= gap_i) begin
      strobe_o <= !strobe_o;
      cnt <= 16'h0;
    end else begin
      cnt <= cnt + 16'h1;
    end
  end
endmodule
`default_nettype wire

// [test/tb_top.sv]
// Self-checking testbench for the watchdog
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import wdog_pkg::*;
  logic clock_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic run = 1'b0;
  logic [15:0] gap = 16'h64;
  logic [2:0] sel = 3'h0;
  logic strobe, n, oe;
  int fail_count = 0;
  int compares = 0;
  always #20 clock_i = ~clock_i;
  host_model u_host (.clock_i(clock_i), .run_i(run), .gap_i(gap), .strobe_o(strobe));
  pin_selectable_watchdog #(.SETTLE_CYCLES(32'h14), .PULSE_CYCLES(32'h1E), .TIME_DIV(100))
  u_dut (.clock_i(clock_i), .rst_b_i(rst_b_i), .strobe_in_i(strobe),
    .timing_sel_0_i(sel[0]), .timing_sel_1_i(sel[1]), .timing_sel_2_i(sel[2]),
    .fault_pulse_n_o(n), .fault_pulse_oe_o(oe));
  // ========
  // Shared tasks
  task automatic final_report;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    compares++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      fail_count++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, lo);
    end
  endtask
  task automatic wait_fall(input int lim, output int c);
    c = 0;
    while (n !== 1'b0 && c < lim) begin
      @(negedge clock_i);
      c++;
    end
    if (c >= lim) begin
      fail_count++;
      $display("mismatch at %0t: got %0h expected %0h", $time, c, lim);
      final_report();
    end
  endtask
  task automatic width(output int w);
    int bad;
    w = 0;
    bad = 0;
    while (n === 1'b0 && w < 100) begin
      bad += (oe !== 1'b1);
      @(negedge clock_i);
      w++;
    end
    check(bad, 0, 0);
  endtask
  task automatic watch(input int cyc, output int lows);
    lows = 0;
    repeat (cyc) begin
      @(negedge clock_i);
      lows += (n !== 1'b1);
    end
  endtask
  // ========
  // Scenarios
  task automatic t_reset_fault;
    int c;
    wait_fall(700, c);
    check(c, 520, 535);
    width(c);
    check(c, 30, 30);
    wait_fall(400, c);
    check(c, 250, 253);
    width(c);
    check(c, 30, 30);
    $display("test reset_fault done");
  endtask
  task automatic t_strobe;
    int lows;
    run <= 1'b1;
    watch(2000, lows);
    check(lows, 0, 0);
    $display("test strobe done");
  endtask
  task automatic t_disable;
    int lows;
    sel <= 3'h3;
    run <= 1'b0;
    watch(3000, lows);
    check(lows, 0, 0);
    $display("test disable done");
  endtask
  task automatic t_select;
    int c;
    sel <= 3'h1;
    watch(500, c);
    run <= 1'b1;
    watch(500, c);
    run <= 1'b0;
    wait_fall(5000, c);
    check(c + 1000, 5020, 5035);
    width(c);
    check(c, 30, 30);
    $display("test select done");
  endtask
  initial begin
    repeat (6) @(negedge clock_i);
    rst_b_i = 1'b1;
    t_reset_fault();
    t_strobe();
    t_disable();
    t_select();
    final_report();
  end
endmodule
`default_nettype wire
